// ---- mcd_pkg.sv ----
// shared constants and types for the microcoded instruction dispatch block
package mcd_pkg;

   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int OPC_W       = 9;
   localparam int AC_W        = 4;
   localparam int DW_W        = 24;
   localparam int DT_DEPTH    = 512;
   localparam int UW_W        = 75;
   localparam int US_DEPTH    = 1280;
   localparam int UA_W        = 11;
   localparam int WORD_W      = 36;
   localparam int ADR_W       = 18;
   localparam int STK_DEPTH   = 4;

   // ----------------------------------------
   // dispatch word fields, bit 0 is msb as printed
   // ----------------------------------------
   localparam int DW_FETCH_HI = 0;
   localparam int DW_STORE_HI = 3;
   localparam int DW_ENTRY_HI = 14;
   localparam int DW_PAR_BIT  = 6;
   localparam int CLS_W       = 3;
   localparam int ENT_W       = 10;

   // ----------------------------------------
   // instruction word fields, bit 0 is msb
   // ----------------------------------------
   localparam int IW_IND_BIT  = 13;
   localparam int IW_IDX_HI   = 14;
   localparam int IW_Y_HI     = 18;

   // ----------------------------------------
   // microword fields, low order bits
   // ----------------------------------------
   localparam int UW_JMP_LO   = 0;
   localparam int UW_DSP_LO   = 11;
   localparam int UW_CALL_BIT = 15;
   localparam int UW_RET_BIT  = 16;
   localparam int UW_MEMRQ_BIT = 17;
   localparam int UW_FETCH_BIT = 18;

   // ----------------------------------------
   // fixed operand fetch targets and reset micro address
   // ----------------------------------------
   localparam logic [UA_W-1:0] ADR_FC2 = 11'h02a;
   localparam logic [UA_W-1:0] ADR_FC3 = 11'h02b;
   localparam logic [UA_W-1:0] ADR_FC4 = 11'h02c;
   localparam logic [UA_W-1:0] ADR_FC5 = 11'h02d;
   localparam logic [UA_W-1:0] ADR_FC6 = 11'h02e;
   localparam logic [UA_W-1:0] ADR_FC7 = 11'h02f;
   localparam logic [UA_W-1:0] RST_UADR = 11'h000;

   // ----------------------------------------
   // dispatch selects
   // ----------------------------------------
   typedef enum logic [3:0] {
      MCD_DSP_NONE   = 4'h0,
      MCD_DSP_NEXT   = 4'h1,
      MCD_DSP_AMOD   = 4'h2,
      MCD_DSP_FETCH  = 4'h3,
      MCD_DSP_ENTRY  = 4'h4,
      MCD_DSP_STORE  = 4'h5
   } mcd_dsp_t;

   typedef struct packed {
      logic             we;
      logic [UA_W-1:0]  adr;
      logic [UW_W-1:0]  data;
   } mcd_uload_t;

   typedef struct packed {
      logic             we;
      logic [OPC_W-1:0] adr;
      logic [DW_W-1:0]  data;
   } mcd_dload_t;

endpackage : mcd_pkg

// ---- mcd_dispatch.sv ----
// instruction dispatch and main microcode sequencer
`timescale 1ns/1ps
`default_nettype none

module mcd_dispatch
(
   input  wire logic                         CLK_SYS_I,
   input  wire logic                         RST_I,
   input  wire logic                         AVS_READ_I,
   input  wire logic                         AVS_WRITE_I,
   input  wire logic [3:0]                   AVS_ADDRESS_I,
   input  wire logic [31:0]                  AVS_WRITEDATA_I,
   output logic      [31:0]                  AVS_READDATA_O,
   output logic                              AVS_WAITREQUEST_O,
   input  wire logic                         OPCODE_LOAD_STROBE_I,
   input  wire logic [mcd_pkg::WORD_W-1:0]   FETCH_WORD_I,
   input  wire logic                         MEM_WORD_VALID_I,
   input  wire logic [mcd_pkg::WORD_W-1:0]   MEM_WORD_I,
   input  wire logic [mcd_pkg::WORD_W-1:0]   INDEX_REG_DATA_I,
   input  wire logic                         PRIORITY_INTERRUPT_REQ_I,
   input  wire logic                         TRAP_REQ_I,
   output logic      [mcd_pkg::AC_W-1:0]     INDEX_REG_SEL_O,
   output logic                              MEM_REQ_O,
   output logic      [mcd_pkg::ADR_W-1:0]    MEM_ADDR_O,
   output logic                              INSTR_FETCH_REQ_O,
   output logic      [mcd_pkg::ADR_W-1:0]    EFF_ADDR_O,
   output logic      [mcd_pkg::UW_W-1:0]     MICROWORD_O,
   output logic      [mcd_pkg::UA_W-1:0]     MICRO_ADDR_O,
   output logic                              PREFETCH_EN_O
);

   // ----------------------------------------
   // register map, word addresses
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_LDADR  = 4'h1;
   localparam logic [3:0] REG_D0     = 4'h2;
   localparam logic [3:0] REG_D1     = 4'h3;
   localparam logic [3:0] REG_D2     = 4'h4;
   localparam logic [3:0] REG_DTWR   = 4'h5;
   localparam logic [3:0] REG_UWR    = 4'h6;
   localparam logic [3:0] REG_STAT   = 4'h7;
   localparam logic [3:0] REG_DBUF   = 4'h8;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [mcd_pkg::DW_W-1:0]   dtab [mcd_pkg::DT_DEPTH];
   logic [mcd_pkg::UW_W-1:0]   ustore [mcd_pkg::US_DEPTH];

   logic                         run;
   logic [mcd_pkg::UA_W-1:0]     ld_adr;
   logic [95:0]                  ld_data;
   logic [mcd_pkg::OPC_W-1:0]    opc_hold;
   logic [mcd_pkg::AC_W-1:0]     ac_hold;
   logic [mcd_pkg::WORD_W-1:0]   arith_extension_reg;
   logic [mcd_pkg::DW_W-1:0]     dword_buf;
   logic [mcd_pkg::UW_W-1:0]     uinstr;
   logic [mcd_pkg::UA_W-1:0]     uadr;
   logic [mcd_pkg::UA_W-1:0]     stk [mcd_pkg::STK_DEPTH];
   logic [2:0]                   stk_cnt;
   logic                         fetch_issued;
   logic                         wait_mem;
   logic                         bus_ack;

   // ----------------------------------------
   // opcode latch, transparent while loading
   // ----------------------------------------
   wire  [mcd_pkg::OPC_W-1:0] fetch_opc = FETCH_WORD_I[35 -: mcd_pkg::OPC_W];
   wire  [mcd_pkg::AC_W-1:0]  fetch_ac  = FETCH_WORD_I[26 -: mcd_pkg::AC_W];
   wire  [mcd_pkg::OPC_W-1:0] opcode_latch =
      OPCODE_LOAD_STROBE_I ? fetch_opc : opc_hold;

   // ----------------------------------------
   // dispatch word fields
   // ----------------------------------------
   wire [mcd_pkg::CLS_W-1:0] fetch_cls  =
      dword_buf[23-mcd_pkg::DW_FETCH_HI -: mcd_pkg::CLS_W];
   wire [mcd_pkg::CLS_W-1:0] store_cls  =
      dword_buf[23-mcd_pkg::DW_STORE_HI -: mcd_pkg::CLS_W];
   wire [mcd_pkg::ENT_W-1:0] entry_pt   =
      dword_buf[23-mcd_pkg::DW_ENTRY_HI -: mcd_pkg::ENT_W];

   // ----------------------------------------
   // instruction word fields
   // ----------------------------------------
   wire                      ind_bit = arith_extension_reg[35-mcd_pkg::IW_IND_BIT];
   wire [mcd_pkg::AC_W-1:0]  idx_fld = arith_extension_reg[35-mcd_pkg::IW_IDX_HI -: 4];
   wire [mcd_pkg::ADR_W-1:0] y_fld   = arith_extension_reg[mcd_pkg::ADR_W-1:0];
   wire [mcd_pkg::ADR_W-1:0] idx_sum = y_fld + INDEX_REG_DATA_I[mcd_pkg::ADR_W-1:0];
   wire [mcd_pkg::ADR_W-1:0] ea      = (idx_fld != 4'h0) ? idx_sum : y_fld;

   // ----------------------------------------
   // microword decode
   // ----------------------------------------
   wire [mcd_pkg::UA_W-1:0] jmp_adr = uinstr[mcd_pkg::UW_JMP_LO +: mcd_pkg::UA_W];
   wire [3:0]               dsp_sel = uinstr[mcd_pkg::UW_DSP_LO +: 4];
   wire                     u_call  = uinstr[mcd_pkg::UW_CALL_BIT];
   wire                     u_ret   = uinstr[mcd_pkg::UW_RET_BIT];
   wire                     u_memrq = uinstr[mcd_pkg::UW_MEMRQ_BIT];
   wire                     u_fetch = uinstr[mcd_pkg::UW_FETCH_BIT];

   wire is_next  = dsp_sel == mcd_pkg::MCD_DSP_NEXT;
   wire is_amod  = dsp_sel == mcd_pkg::MCD_DSP_AMOD;
   wire is_fetch = dsp_sel == mcd_pkg::MCD_DSP_FETCH;
   wire is_entry = dsp_sel == mcd_pkg::MCD_DSP_ENTRY;
   wire is_store = dsp_sel == mcd_pkg::MCD_DSP_STORE;

   // next dispatch: interrupt, trap, then instruction (low two bits)
   wire [1:0] next_val = PRIORITY_INTERRUPT_REQ_I ? 2'h2 :
                         TRAP_REQ_I               ? 2'h1 : 2'h0;
   // held back until the next fetch has gone out
   wire next_block = is_next && !(fetch_issued || u_fetch);
   // indirection: wait for memory word before moving on
   wire amod_block = is_amod && ind_bit && !MEM_WORD_VALID_I;
   wire stall      = next_block || amod_block || wait_mem;

   logic [mcd_pkg::UA_W-1:0] fetch_tgt;
   always_comb
   begin
      unique case (fetch_cls)
         3'h0, 3'h1: fetch_tgt = {1'b0, entry_pt};
         3'h2:       fetch_tgt = mcd_pkg::ADR_FC2;
         3'h3:       fetch_tgt = mcd_pkg::ADR_FC3;
         3'h4:       fetch_tgt = mcd_pkg::ADR_FC4;
         3'h5:       fetch_tgt = mcd_pkg::ADR_FC5;
         3'h6:       fetch_tgt = mcd_pkg::ADR_FC6;
         default:    fetch_tgt = mcd_pkg::ADR_FC7;
      endcase
   end

   // jump address modified by dispatch value in the same cycle; fetch, entry and return replace it
   logic [mcd_pkg::UA_W-1:0] next_uadr;
   always_comb
   begin
      if (u_ret && stk_cnt != 3'h0)
         next_uadr = stk[0];
      else if (is_next)
         next_uadr = jmp_adr | {9'h000, next_val};
      else if (is_amod)
         next_uadr = jmp_adr | {9'h000, ind_bit, idx_fld != 4'h0};
      else if (is_fetch)
         next_uadr = fetch_tgt;
      else if (is_entry)
         next_uadr = {1'b0, entry_pt};
      else if (is_store)
         next_uadr = jmp_adr | {8'h00, store_cls};
      else
         next_uadr = jmp_adr;
   end

   // ----------------------------------------
   // loader and bus decode
   // ----------------------------------------
   wire bus_req   = AVS_READ_I || AVS_WRITE_I;
   wire wr_ctrl   = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_CTRL;
   wire wr_ldadr  = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_LDADR;
   wire wr_d0     = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_D0;
   wire wr_d1     = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_D1;
   wire wr_d2     = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_D2;
   wire wr_dt     = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_DTWR && !run;
   wire wr_us     = AVS_WRITE_I && bus_ack && AVS_ADDRESS_I == REG_UWR && !run;
   wire adv       = run && !stall;

   assign AVS_WAITREQUEST_O = bus_req && !bus_ack;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         bus_ack <= 1'b0;
      else
         bus_ack <= bus_req && !bus_ack;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         run     <= 1'b0;
         ld_adr  <= '0;
         ld_data <= '0;
      end
      else
      begin
         if (wr_ctrl)
            run <= AVS_WRITEDATA_I[0];
         if (wr_ldadr)
            ld_adr <= AVS_WRITEDATA_I[mcd_pkg::UA_W-1:0];
         if (wr_d0)
            ld_data[31:0] <= AVS_WRITEDATA_I;
         if (wr_d1)
            ld_data[63:32] <= AVS_WRITEDATA_I;
         if (wr_d2)
            ld_data[95:64] <= AVS_WRITEDATA_I;
      end
   end

   // no reset on the arrays: contents come only from the loader
   always_ff @(posedge CLK_SYS_I)
   begin
      if (wr_dt)
         dtab[ld_adr[mcd_pkg::OPC_W-1:0]] <= ld_data[mcd_pkg::DW_W-1:0];
      if (wr_us && ld_adr < 11'(mcd_pkg::US_DEPTH))
         ustore[ld_adr] <= ld_data[mcd_pkg::UW_W-1:0];
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         AVS_READDATA_O <= '0;
      else if (AVS_READ_I && !bus_ack)
      begin
         unique case (AVS_ADDRESS_I)
            REG_CTRL:  AVS_READDATA_O <= {31'h0, run};
            REG_LDADR: AVS_READDATA_O <= {21'h0, ld_adr};
            REG_STAT:  AVS_READDATA_O <= {3'h0, ac_hold, stk_cnt, wait_mem, opcode_latch,
                                          1'b0, uadr};
            REG_DBUF:  AVS_READDATA_O <= {8'h00, dword_buf};
            default:   AVS_READDATA_O <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // instruction fetch registers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         opc_hold <= '0;
         ac_hold  <= '0;
         arith_extension_reg <= '0;
      end
      else if (OPCODE_LOAD_STROBE_I)
      begin
         opc_hold <= fetch_opc;
         ac_hold  <= fetch_ac;
         arith_extension_reg <= FETCH_WORD_I;
      end
      else if (is_amod && ind_bit && MEM_WORD_VALID_I && run)
         arith_extension_reg <= MEM_WORD_I;
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         uadr         <= mcd_pkg::RST_UADR;
         uinstr       <= '0;
         dword_buf    <= '0;
         fetch_issued <= 1'b0;
         wait_mem     <= 1'b0;
         EFF_ADDR_O   <= '0;
      end
      else if (adv)
      begin
         uadr   <= next_uadr;
         uinstr <= ustore[next_uadr];
         if (is_next && next_val == 2'h0)
            dword_buf <= dtab[opcode_latch];
         if (is_next)
            fetch_issued <= 1'b0;
         else if (u_fetch)
            fetch_issued <= 1'b1;
         if (is_amod)
            EFF_ADDR_O <= ea;
         wait_mem <= u_memrq;
      end
      else if (wait_mem && MEM_WORD_VALID_I)
         wait_mem <= 1'b0;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         stk_cnt <= '0;
      else if (adv && u_call && !u_ret)
         stk_cnt <= (stk_cnt == 3'h4) ? stk_cnt : stk_cnt + 3'h1;
      else if (adv && u_ret && stk_cnt != 3'h0)
         stk_cnt <= stk_cnt - 3'h1;
   end

   // return stack: entry 0 is top, oldest drops off when full
   genvar gi;
   generate
      for (gi = 0; gi < mcd_pkg::STK_DEPTH; gi++)
      begin : g_stk
         always_ff @(posedge CLK_SYS_I)
         begin
            if (RST_I)
               stk[gi] <= '0;
            else if (adv && u_call && !u_ret)
               stk[gi] <= (gi == 0) ? uadr + 11'h001 : stk[(gi == 0) ? 0 : gi-1];
            else if (adv && u_ret)
               stk[gi] <= (gi == mcd_pkg::STK_DEPTH-1) ? '0 : stk[(gi == 3) ? 3 : gi+1];
         end
      end
   endgenerate

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign MICROWORD_O       = uinstr;
   assign MICRO_ADDR_O      = uadr;
   assign INDEX_REG_SEL_O   = idx_fld;
   assign MEM_REQ_O         = run && ((is_amod && ind_bit) || wait_mem);
   assign MEM_ADDR_O        = ea;
   assign INSTR_FETCH_REQ_O = run && u_fetch;
   assign PREFETCH_EN_O     = fetch_cls == 3'h1 || fetch_cls == 3'h5;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_NEXT_HELD: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      run && is_next && !fetch_issued && !u_fetch |=> $stable(uadr))
      else $error("next dispatch advanced before fetch");
   AST_IRQ_FIRST: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      adv && is_next && PRIORITY_INTERRUPT_REQ_I |=> uadr[1:0] == 2'h2)
      else $error("interrupt not taken first");
   AST_TRAP_SECOND: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      adv && is_next && !PRIORITY_INTERRUPT_REQ_I && TRAP_REQ_I |=> uadr[1:0] == 2'h1)
      else $error("trap not taken second");
   AST_DBUF_LOAD: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !(adv && is_next) |=> $stable(dword_buf))
      else $error("dispatch buffer changed outside next dispatch");
   AST_FC4: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      adv && is_fetch && fetch_cls == 3'h4 |=> uadr == 11'h02c)
      else $error("class 4 target wrong");
   AST_FC7: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      adv && is_fetch && fetch_cls == 3'h7 |=> uadr == 11'h02f)
      else $error("class 7 target wrong");
   AST_ENTRY: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      adv && is_entry && !u_ret |=> uadr == {1'b0, $past(entry_pt)})
      else $error("entry dispatch wrong");
   AST_INDIRECT: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      run && is_amod && ind_bit && !MEM_WORD_VALID_I |=> MEM_REQ_O && $stable(uadr))
      else $error("indirect step did not wait on memory");
   AST_STACK: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      stk_cnt <= 3'h4)
      else $error("return stack too deep");
   COV_IRQ:   cover property (@(posedge CLK_SYS_I) adv && is_next && PRIORITY_INTERRUPT_REQ_I);
   COV_IND:   cover property (@(posedge CLK_SYS_I) adv && is_amod && ind_bit);
   COV_FETCH: cover property (@(posedge CLK_SYS_I) adv && is_fetch && fetch_cls == 3'h5);
   COV_CALL4: cover property (@(posedge CLK_SYS_I) stk_cnt == 3'h4);

endmodule : mcd_dispatch

`default_nettype wire

// ---- mcd_mem_model.sv ----
// partner model: memory replies to indirect requests, index register file
`timescale 1ns/1ps
`default_nettype none
module mcd_mem_model
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic [3:0]                lat_i,
   input  wire logic                      mem_req_i,
   input  wire logic [mcd_pkg::ADR_W-1:0] mem_addr_i,
   input  wire logic [mcd_pkg::AC_W-1:0]  idx_sel_i,
   output logic                           valid_o,
   output logic [mcd_pkg::WORD_W-1:0]     word_o,
   output logic [mcd_pkg::WORD_W-1:0]     idx_data_o
);
   // ----------------------------------------
   // two-level chain: indirect word, then direct word with index 3
   // ----------------------------------------
   localparam logic [35:0] W_IND = 36'h000400200;
   localparam logic [35:0] W_END = 36'h0000fff00;
   logic [mcd_pkg::ADR_W-1:0] addr_log [2];
   logic [35:0]               last = 36'h0;
   logic [3:0]                cnt;
   logic                      n;
   // left half is filler, so adding the wrong half shows
   assign idx_data_o = {18'h2aaaa, idx_sel_i, 14'h0000};
   always @(posedge clk_i)
   begin
      valid_o <= 1'b0;
      word_o  <= ~last;   // released data never keeps the old word
      if (rst_i)
      begin
         n   <= 1'b0;
         cnt <= 4'h0;
      end
      else if (mem_req_i && !valid_o)
      begin
         cnt <= cnt + 4'h1;
         if (cnt == 4'h0)
            addr_log[n] <= mem_addr_i;
         if (cnt >= lat_i)
         begin
            valid_o <= 1'b1;
            word_o  <= n ? W_END : W_IND;
            last    <= n ? W_END : W_IND;
            n       <= !n;
            cnt     <= 4'h0;
         end
      end
   end
endmodule : mcd_mem_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench: microcode load over the register bus, then dispatch runs
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk;
   logic        rst;
   logic        rd;
   logic        wr;
   logic [3:0]  adr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        waitreq;
   logic        strobe;
   logic [35:0] fword;
   logic        mvalid;
   logic [35:0] mword;
   logic [35:0] idat;
   logic        pint;
   logic        trap;
   logic [3:0]  isel;
   logic        mreq;
   logic [17:0] maddr;
   logic        ifreq;
   logic [17:0] eff;
   logic [74:0] uword;
   logic [10:0] uadr;
   logic        pfen;
   logic [3:0]  lat;
   logic [31:0] q;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          cyc = 0;

   mcd_dispatch u_mcd_dispatch
   (
      .CLK_SYS_I(clk), .RST_I(rst), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_ADDRESS_I(adr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(waitreq), .OPCODE_LOAD_STROBE_I(strobe), .FETCH_WORD_I(fword),
      .MEM_WORD_VALID_I(mvalid), .MEM_WORD_I(mword), .INDEX_REG_DATA_I(idat),
      .PRIORITY_INTERRUPT_REQ_I(pint), .TRAP_REQ_I(trap), .INDEX_REG_SEL_O(isel),
      .MEM_REQ_O(mreq), .MEM_ADDR_O(maddr), .INSTR_FETCH_REQ_O(ifreq), .EFF_ADDR_O(eff),
      .MICROWORD_O(uword), .MICRO_ADDR_O(uadr), .PREFETCH_EN_O(pfen)
   );

   mcd_mem_model u_mcd_mem_model
   (
      .clk_i(clk), .rst_i(rst), .lat_i(lat), .mem_req_i(mreq), .mem_addr_i(maddr),
      .idx_sel_i(isel), .valid_o(mvalid), .word_o(mword), .idx_data_o(idat)
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr   <= w;
      rd   <= !w;
      adr  <= a;
      wdat <= d;
      do
         @(posedge clk);
      while (waitreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   function automatic logic [74:0] mw(input logic [10:0] j, input logic [3:0] d,
                                      input logic f);
      return {56'h0, f, 3'b000, d, j};
   endfunction : mw

   function automatic logic [23:0] dw(input logic [2:0] f, input logic [2:0] s,
                                      input logic [9:0] e);
      return {f, s, 8'h00, e};
   endfunction : dw

   task automatic uw(input logic [10:0] a, input logic [74:0] w);
      bus(1'b1, 4'h1, {21'h0, a});
      bus(1'b1, 4'h2, w[31:0]);
      bus(1'b1, 4'h3, w[63:32]);
      bus(1'b1, 4'h4, {21'h0, w[74:64]});
      bus(1'b1, 4'h6, 32'h0);
   endtask : uw

   task automatic dt(input logic [8:0] op, input logic [23:0] w);
      bus(1'b1, 4'h1, {23'h0, op});
      bus(1'b1, 4'h2, {8'h0, w});
      bus(1'b1, 4'h5, 32'h0);
   endtask : dt

   // a second reset each time, so every run starts from microword zero
   task automatic go(input logic [35:0] w, input logic p, input logic t);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst    <= 1'b0;
      fword  <= w;
      strobe <= 1'b1;
      pint   <= p;
      trap   <= t;
      repeat (2) @(posedge clk);
      strobe <= 1'b0;
      fword  <= ~w;
      bus(1'b1, 4'h0, 32'h1);
   endtask : go

   task automatic reach(input logic [10:0] e);
      for (int i = 0; i < 300 && uadr !== e; i++)
         @(posedge clk);
      check("micro address", {21'h0, e}, {21'h0, uadr});
   endtask : reach

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         $display("timeout");
         end_sim;
      end
   end

   initial
   begin
      {rst, rd, wr, adr, wdat, strobe, fword, pint, trap, lat} = '0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      uw(11'h000, mw(11'h100, mcd_pkg::MCD_DSP_NEXT, 1'b1));
      uw(11'h101, mw(11'h101, mcd_pkg::MCD_DSP_NONE, 1'b0));
      uw(11'h102, mw(11'h102, mcd_pkg::MCD_DSP_NONE, 1'b1));
      uw(11'h100, mw(11'h110, mcd_pkg::MCD_DSP_AMOD, 1'b0));
      uw(11'h200, mw(11'h300, mcd_pkg::MCD_DSP_STORE, 1'b0));
      for (int i = 0; i < 8; i++)
      begin
         uw(11'h300 + 11'(i), mw(11'h300 + 11'(i), mcd_pkg::MCD_DSP_NONE, 1'b0));
         uw(11'h28 + 11'(i), mw(11'h28 + 11'(i), mcd_pkg::MCD_DSP_NONE, 1'b0));
         dt(9'(i), dw(3'(i), 3'(7 - i), 10'h200));
      end
      uw(11'h02c, mw(11'h000, mcd_pkg::MCD_DSP_ENTRY, 1'b0));
      uw(11'h110, mw(11'h000, mcd_pkg::MCD_DSP_FETCH, 1'b0));
      uw(11'h111, mw(11'h000, mcd_pkg::MCD_DSP_FETCH, 1'b0));
      uw(11'h112, mw(11'h100, mcd_pkg::MCD_DSP_NONE, 1'b0));
      uw(11'h113, mw(11'h100, mcd_pkg::MCD_DSP_NONE, 1'b0));
      dt(9'h008, dw(3'h0, 3'h2, 10'h200));
      dt(9'h009, dw(3'h0, 3'h0, 10'h010));
      // two nested calls, returns must unwind in order past wrong jump fields
      uw(11'h010, mw(11'h020, mcd_pkg::MCD_DSP_NONE, 1'b0) | 75'h8000);
      uw(11'h020, mw(11'h030, mcd_pkg::MCD_DSP_NONE, 1'b0) | 75'h8000);
      uw(11'h030, mw(11'h3ff, mcd_pkg::MCD_DSP_NONE, 1'b0) | 75'h10000);
      uw(11'h021, mw(11'h3ff, mcd_pkg::MCD_DSP_NONE, 1'b0) | 75'h10000);
      uw(11'h011, mw(11'h011, mcd_pkg::MCD_DSP_NONE, 1'b0));
      bus(1'b0, 4'hf, 32'h0);
      check("unmapped read", 32'h0, q);
      go(36'h0, 1'b1, 1'b1);
      reach(11'h102);
      check("fetch request", 32'h1, {31'h0, ifreq});
      go(36'h0, 1'b0, 1'b1);
      reach(11'h101);
      check("fetch request", 32'h0, {31'h0, ifreq});
      check("microword", 32'h0000_0101, uword[31:0]);
      for (int c = 0; c < 8; c++)
      begin
         go({9'(c), 27'h0}, 1'b0, 1'b0);
         reach((c < 2 || c == 4) ? 11'h307 - 11'(c) : 11'h28 + 11'(c));
         check("prefetch", {31'h0, (c == 1 || c == 5)}, {31'h0, pfen});
         bus(1'b0, 4'h8, 32'h0);
         check("dispatch buffer", {8'h0, dw(3'(c), 3'(7 - c), 10'h200)}, q);
         bus(1'b0, 4'h7, 32'h0);
         check("opcode", 32'(c), {23'h0, q[20:12]});
      end
      for (int l = 0; l < 8; l += 7)
      begin
         lat <= 4'(l);
         go({9'h008, 4'h5, 1'b1, 4'h1, 18'h00010}, 1'b0, 1'b0);
         reach(11'h302);
         check("effective address", 32'h0bf00, {14'h0, eff});
         check("first request", 32'h04010, {14'h0, u_mcd_mem_model.addr_log[0]});
         check("second request", 32'h00200, {14'h0, u_mcd_mem_model.addr_log[1]});
         bus(1'b0, 4'h7, 32'h0);
         check("accumulator", 32'h5, {28'h0, q[28:25]});
      end
      go({9'h009, 27'h0}, 1'b0, 1'b0);
      reach(11'h011);
      bus(1'b0, 4'h7, 32'h0);
      check("stack depth", 32'h0, {29'h0, q[24:22]});
      // table writes are refused while running, so the old store class stays
      dt(9'h000, dw(3'h0, 3'h0, 10'h200));
      go(36'h0, 1'b0, 1'b0);
      reach(11'h307);
      end_sim;
   end
endmodule : testbench
`default_nettype wire
